// file: logic/tsp_cfg.svh
// Timing counts, field positions and reset values of the touch serial port
`ifndef TSP_CFG_SVH
`define TSP_CFG_SVH
`define TSP_CLK_MHZ 100
`define TSP_CMD_BITS 8
`define TSP_SHORT_READ 8
`define TSP_LONG_READ 16
`define TSP_WORD_BITS 16
`define TSP_CMD_LONG_BIT 3
`define TSP_CONV_NS 1000
`define TSP_CONV_CYCLES ((`TSP_CONV_NS * `TSP_CLK_MHZ + 999) / 1000)
`define TSP_HOST_HALF 8
`define TSP_FIFO_DEPTH 32
`define TSP_PEN_RESET 1'b1
`define TSP_CS_RESET 1'b1
`endif

// file: logic/tsp_pkg.sv
// Types of the host end of the touch serial port
package tsp_pkg;
    typedef enum logic [2:0] {
        TSP_H_IDLE,
        TSP_H_LEAD,
        TSP_H_CMD,
        TSP_H_BUSY,
        TSP_H_READ,
        TSP_H_LAG
    } tsp_host_state_type;
endpackage : tsp_pkg

// file: logic/tsp_if.sv
// Serial link between the host and the touch controller port
interface tsp_if;
    logic cs_n;
    logic sclk;
    logic serial_in_pin;
    logic serial_out_pin;
    logic serial_out_oe;
    logic pen_touch_irq_n;
    // Undriven output line is seen as low by the host
    logic serial_out_level;
    assign serial_out_level = serial_out_oe & serial_out_pin;
    modport dev (
        input cs_n, sclk, serial_in_pin,
        output serial_out_pin, serial_out_oe, pen_touch_irq_n
    );
    modport host (
        output cs_n, sclk, serial_in_pin,
        input serial_out_level, pen_touch_irq_n
    );
endinterface : tsp_if

// file: logic/tsp_device.sv
// Touch controller end: serial slave, result FIFO and pen interrupt
`include "tsp_cfg.svh"

module tsp_fifo #(
    parameter int WIDTH = `TSP_WORD_BITS,
    parameter int DEPTH = `TSP_FIFO_DEPTH
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic [WIDTH-1:0] in_data_in,
    input wire logic in_valid_in,
    output logic in_ready_out,
    output logic [WIDTH-1:0] out_data_out,
    output logic out_valid_out,
    input wire logic out_ready_in
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = AW + 1;

    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_check
        $error("tsp_fifo depth must be a power of two of at least 2");
    end

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_ptr_q;
    logic [AW-1:0] rd_ptr_q;
    logic [CW-1:0] count_q;
    logic [CW-1:0] count_d;
    logic not_full_q;

    wire push = in_valid_in & not_full_q;
    wire pop = out_ready_in & (count_q != '0);
    assign count_d = count_q + CW'(push) - CW'(pop);
    assign in_ready_out = not_full_q;
    assign out_valid_out = count_q != '0;
    assign out_data_out = mem_q[rd_ptr_q];

    always_ff @(posedge clk_in) begin
        if (push) begin
            mem_q[wr_ptr_q] <= in_data_in;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q <= '0;
            not_full_q <= 1'b1;
        end else begin
            wr_ptr_q <= wr_ptr_q + AW'(push);
            rd_ptr_q <= rd_ptr_q + AW'(pop);
            count_q <= count_d;
            not_full_q <= count_d != CW'(DEPTH);
        end
    end
endmodule : tsp_fifo

module tsp_device #(
    parameter int CONV_CYCLES = `TSP_CONV_CYCLES
) (
    input wire logic clk_in,
    input wire logic rst_in,
    tsp_if.dev link,
    input wire logic pen_touch_in,
    input wire logic [`TSP_WORD_BITS-1:0] res_data_in,
    input wire logic res_valid_in,
    output logic res_ready_out,
    output logic cmd_valid_out,
    output logic [`TSP_CMD_BITS-1:0] cmd_byte_out,
    output logic conv_busy_out,
    output logic conv_done_out
);
    localparam int WB = `TSP_WORD_BITS;
    localparam int CB = `TSP_CMD_BITS;

    if (CONV_CYCLES < 2 || CONV_CYCLES > 65535) begin : g_check
        $error("tsp_device conversion time out of range");
    end

    // Pin synchronisers; edge detection looks at stages two and three only
    logic [2:0] sclk_sync_q;
    logic [1:0] cs_sync_q;
    logic [1:0] sdi_sync_q;

    logic [3:0] bit_cnt_q;
    logic [CB-1:0] cmd_sr_q;
    logic cmd_taken_q;
    logic [15:0] conv_cnt_q;
    logic busy_q;
    logic conv_end_q;
    logic [WB-1:0] tx_sr_q;
    logic data_phase_q;
    logic sdo_q;
    logic sdo_oe_q;
    logic pen_n_q;
    logic cmd_valid_q;
    logic [CB-1:0] cmd_byte_q;
    logic done_q;

    logic [WB-1:0] fifo_data;
    logic fifo_valid;
    logic fifo_ready;

    wire sclk_rise = sclk_sync_q[1] & ~sclk_sync_q[2];
    wire sclk_fall = ~sclk_sync_q[1] & sclk_sync_q[2];
    wire selected = ~cs_sync_q[1];
    wire rise_sel = selected & sclk_rise;
    wire fall_sel = selected & sclk_fall;
    wire cmd_done = rise_sel & ~cmd_taken_q & (bit_cnt_q == 4'(CB - 1));
    wire [CB-1:0] cmd_next = {cmd_sr_q[CB-2:0], sdi_sync_q[1]};
    wire conv_done = busy_q & (conv_cnt_q == 16'h0001);
    wire [WB-1:0] load_word = fifo_valid ? fifo_data : '0;
    wire pop_word = conv_done & fifo_valid;

    tsp_fifo #(
        .WIDTH(WB),
        .DEPTH(`TSP_FIFO_DEPTH)
    ) u_fifo (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .in_data_in(res_data_in),
        .in_valid_in(res_valid_in),
        .in_ready_out(fifo_ready),
        .out_data_out(fifo_data),
        .out_valid_out(fifo_valid),
        .out_ready_in(pop_word)
    );

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            sclk_sync_q <= '0;
            cs_sync_q <= {2{`TSP_CS_RESET}};
            sdi_sync_q <= '0;
        end else begin
            sclk_sync_q <= {sclk_sync_q[1:0], link.sclk};
            cs_sync_q <= {cs_sync_q[0], link.cs_n};
            sdi_sync_q <= {sdi_sync_q[0], link.serial_in_pin};
        end
    end

    // Command shifter: rising sample, msb first, command
    always_ff @(posedge clk_in) begin
        if (rst_in || !selected) begin
            bit_cnt_q <= '0;
            cmd_sr_q <= '0;
            cmd_taken_q <= 1'b0;
        end else if (rise_sel && !cmd_taken_q) begin
            cmd_sr_q <= cmd_next;
            bit_cnt_q <= bit_cnt_q + 4'h1;
            cmd_taken_q <= cmd_done;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            cmd_valid_q <= 1'b0;
            cmd_byte_q <= '0;
        end else begin
            cmd_valid_q <= cmd_done;
            if (cmd_done) begin
                cmd_byte_q <= cmd_next;
            end
        end
    end

    // Conversion timer, restarted by every command
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            busy_q <= 1'b0;
            conv_cnt_q <= '0;
            done_q <= 1'b0;
        end else begin
            done_q <= conv_done;
            if (cmd_done) begin
                busy_q <= 1'b1;
                conv_cnt_q <= 16'(CONV_CYCLES);
            end else if (conv_done) begin
                busy_q <= 1'b0;
                conv_cnt_q <= '0;
            end else if (busy_q) begin
                conv_cnt_q <= conv_cnt_q - 16'h0001;
            end
        end
    end

    // Result shifter; the word is only loaded when conversion ends, so the
    // falling edge right after the command never shifts it
    always_ff @(posedge clk_in) begin
        if (rst_in || !selected) begin
            tx_sr_q <= '0;
            data_phase_q <= 1'b0;
            sdo_q <= 1'b0;
        end else if (conv_done) begin
            tx_sr_q <= load_word;
            data_phase_q <= 1'b1;
            sdo_q <= load_word[WB-1];
        end else if (fall_sel && data_phase_q) begin
            tx_sr_q <= {tx_sr_q[WB-2:0], 1'b0};
            sdo_q <= tx_sr_q[WB-2];
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            sdo_oe_q <= 1'b0;
        end else begin
            sdo_oe_q <= selected;
        end
    end

    // Touch latch: conversion end wins over a release in the same cycle
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            conv_end_q <= 1'b0;
        end else if (conv_done) begin
            conv_end_q <= 1'b1;
        end else if (!pen_touch_in) begin
            conv_end_q <= 1'b0;
        end
    end

    // pen line: low while touched until end, low while busy
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            pen_n_q <= `TSP_PEN_RESET;
        end else begin
            pen_n_q <= ~((pen_touch_in & ~conv_end_q & ~conv_done) | (busy_q & ~conv_done) | cmd_done);
        end
    end

    assign link.serial_out_pin = sdo_q;
    assign link.serial_out_oe = sdo_oe_q;
    assign link.pen_touch_irq_n = pen_n_q;
    assign res_ready_out = fifo_ready;
    assign cmd_valid_out = cmd_valid_q;
    assign cmd_byte_out = cmd_byte_q;
    assign conv_busy_out = busy_q;
    assign conv_done_out = done_q;
endmodule : tsp_device

// file: logic/tsp_host.sv
// Host end: serial master making the link clock by a divider
`include "tsp_cfg.svh"

module tsp_host #(
    parameter int HALF_CYCLES = `TSP_HOST_HALF
) (
    input wire logic clk_in,
    input wire logic rst_in,
    tsp_if.host link,
    input wire logic start_in,
    input wire logic [`TSP_CMD_BITS-1:0] cmd_in,
    input wire logic long_read_in,
    output logic ready_out,
    output logic [`TSP_WORD_BITS-1:0] data_out,
    output logic done_out
);
    localparam int WB = `TSP_WORD_BITS;
    localparam int CB = `TSP_CMD_BITS;

    // The device finds edges by oversampling, so it needs several cycles a phase
    if (HALF_CYCLES < 4 || HALF_CYCLES > 255) begin : g_check
        $error("tsp_host half period out of range");
    end

    tsp_pkg::tsp_host_state_type state_q;
    logic [7:0] div_q;
    logic sclk_q;
    logic cs_n_q;
    logic mosi_q;
    logic [CB-1:0] tx_q;
    logic [WB-1:0] rx_q;
    logic [4:0] cnt_q;
    logic [4:0] nread_q;
    logic seen_low_q;
    logic ready_q;
    logic done_q;
    logic [WB-1:0] data_q;
    logic [1:0] pen_sync_q;
    logic [1:0] miso_sync_q;

    wire tick = div_q == 8'(HALF_CYCLES - 1);
    wire pen_high = pen_sync_q[1];
    wire idle = state_q == tsp_pkg::TSP_H_IDLE;

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            pen_sync_q <= '1;
            miso_sync_q <= '0;
        end else begin
            pen_sync_q <= {pen_sync_q[0], link.pen_touch_irq_n};
            miso_sync_q <= {miso_sync_q[0], link.serial_out_level};
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in || idle || tick) begin
            div_q <= '0;
        end else begin
            div_q <= div_q + 8'h01;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            state_q <= tsp_pkg::TSP_H_IDLE;
            sclk_q <= 1'b0;
            cs_n_q <= `TSP_CS_RESET;
            mosi_q <= 1'b0;
            tx_q <= '0;
            rx_q <= '0;
            cnt_q <= '0;
            nread_q <= '0;
            seen_low_q <= 1'b0;
            ready_q <= 1'b1;
            done_q <= 1'b0;
            data_q <= '0;
        end else begin
            done_q <= 1'b0;
            case (state_q)
                tsp_pkg::TSP_H_IDLE: begin
                    if (start_in) begin
                        cs_n_q <= 1'b0;
                        tx_q <= cmd_in;
                        mosi_q <= cmd_in[CB-1];
                        nread_q <= cmd_in[`TSP_CMD_LONG_BIT] ? 5'(`TSP_SHORT_READ) : 5'(`TSP_LONG_READ);
                        cnt_q <= '0;
                        ready_q <= 1'b0;
                        state_q <= tsp_pkg::TSP_H_LEAD;
                    end
                end
                tsp_pkg::TSP_H_LEAD: begin
                    if (tick) begin
                        state_q <= tsp_pkg::TSP_H_CMD;
                    end
                end
                tsp_pkg::TSP_H_CMD: begin
                    if (tick && !sclk_q) begin
                        sclk_q <= 1'b1;
                        cnt_q <= cnt_q + 5'h01;
                    end else if (tick) begin
                        sclk_q <= 1'b0;
                        if (cnt_q == 5'(CB)) begin
                            cnt_q <= '0;
                            seen_low_q <= 1'b0;
                            mosi_q <= 1'b0;
                            state_q <= tsp_pkg::TSP_H_BUSY;
                        end else begin
                            mosi_q <= tx_q[CB-2];
                            tx_q <= {tx_q[CB-2:0], 1'b0};
                        end
                    end
                end
                tsp_pkg::TSP_H_BUSY: begin
                    // wait for busy to fall then rise
                    if (!pen_high) begin
                        seen_low_q <= 1'b1;
                    end else if (seen_low_q) begin
                        state_q <= tsp_pkg::TSP_H_READ;
                    end
                end
                tsp_pkg::TSP_H_READ: begin
                    if (tick && !sclk_q) begin
                        sclk_q <= 1'b1;
                        rx_q <= {rx_q[WB-2:0], miso_sync_q[1]};
                        cnt_q <= cnt_q + 5'h01;
                    end else if (tick) begin
                        sclk_q <= 1'b0;
                        if (cnt_q == nread_q) begin
                            state_q <= tsp_pkg::TSP_H_LAG;
                        end
                    end
                end
                tsp_pkg::TSP_H_LAG: begin
                    if (tick) begin
                        cs_n_q <= 1'b1;
                        done_q <= 1'b1;
                        ready_q <= 1'b1;
                        data_q <= (nread_q == 5'(`TSP_LONG_READ)) ? rx_q : {8'h00, rx_q[7:0]};
                        state_q <= tsp_pkg::TSP_H_IDLE;
                    end
                end
                default: begin
                    state_q <= tsp_pkg::TSP_H_IDLE;
                end
            endcase
        end
    end

    assign link.cs_n = cs_n_q;
    assign link.sclk = sclk_q;
    assign link.serial_in_pin = mosi_q;
    assign ready_out = ready_q;
    assign data_out = data_q;
    assign done_out = done_q;
endmodule : tsp_host

// file: verification/tsp_link_monitor.sv
// Concurrent checks on the serial link between host and touch controller
module tsp_link_monitor #(
    parameter int CONV_CYCLES = 100
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic serial_in_pin,
    input wire logic serial_out_pin,
    input wire logic serial_out_oe,
    input wire logic pen_touch_irq_n
);
    timeunit 1ns;
    timeprecision 1ps;
    logic sclk_q;
    logic [5:0] rise_cnt_q;
    logic [15:0] wait_cnt_q;
    wire logic sclk_rise;
    wire logic after_cmd;
    assign sclk_rise = sclk & ~sclk_q;
    assign after_cmd = rise_cnt_q == 6'h08;
    // Rising edges counted per frame; cleared while deselected
    always_ff @(posedge clk_in) begin
        sclk_q <= sclk;
        rise_cnt_q <= (rst_in | cs_n) ? 6'h00 : rise_cnt_q + {5'h00, sclk_rise};
        wait_cnt_q <= (rst_in | ~after_cmd) ? 16'h0000 : wait_cnt_q + 16'h0001;
    end
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);
    a_sclk_idle_low: assert property (cs_n |-> !sclk)
        else $error("link clock high while deselected");
    a_out_on_fall: assert property ($changed(serial_out_pin) |-> !sclk && !$past(sclk) && !$past(sclk, 2))
        else $error("device output changed near a rising clock");
    a_in_held: assert property ($rose(sclk) |-> $stable(serial_in_pin) ##1 $stable(serial_in_pin))
        else $error("host input moved around a rising clock");
    a_busy_after_cmd: assert property ($fell(pen_touch_irq_n) && !cs_n |-> after_cmd && sclk)
        else $error("busy fell before the eighth rising clock");
    a_frame_len: assert property ($rose(cs_n) |-> rise_cnt_q == 6'h10 || rise_cnt_q == 6'h18)
        else $error("frame length neither 16 nor 24 clocks");
    a_clock_after_busy: assert property ($rose(sclk) && rise_cnt_q >= 6'h08 |-> pen_touch_irq_n)
        else $error("read clock issued while busy low");
    a_conv_end: assert property ($rose(pen_touch_irq_n) && after_cmd |->
        wait_cnt_q >= CONV_CYCLES && wait_cnt_q <= CONV_CYCLES + 6)
        else $error("busy released at the wrong time");
    a_oe_release: assert property ($rose(cs_n) |-> ##[0:5] !serial_out_oe)
        else $error("output still driven after deselect");
    a_oe_idle: assert property (cs_n [*6] |-> !serial_out_oe)
        else $error("output driven while deselected");
endmodule : tsp_link_monitor

// file: verification/tb_top.sv
// Self-checking bench joining the host end and the touch controller end
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int CONV = 20;
    logic clk_in;
    logic rst_in;
    logic start_in;
    logic [7:0] cmd_in;
    logic pen_touch_in;
    logic [15:0] res_data_in;
    logic res_valid_in;
    logic host_ready, host_done, res_ready, cmd_valid, conv_busy, conv_done;
    logic [15:0] host_data;
    logic [7:0] cmd_byte;
    int n_errors = 0;
    int samples_checked = 0;
    int cycles = 0;
    int n_cmds = 0;
    int n_conv = 0;

    tsp_if link();
    tsp_device #(.CONV_CYCLES(CONV)) i_tsp_device (
        .clk_in(clk_in), .rst_in(rst_in), .link(link), .pen_touch_in(pen_touch_in),
        .res_data_in(res_data_in), .res_valid_in(res_valid_in), .res_ready_out(res_ready),
        .cmd_valid_out(cmd_valid), .cmd_byte_out(cmd_byte), .conv_busy_out(conv_busy),
        .conv_done_out(conv_done));
    // Read length comes from the command, so the spare length input is tied
    tsp_host i_tsp_host (
        .clk_in(clk_in), .rst_in(rst_in), .link(link), .start_in(start_in), .cmd_in(cmd_in),
        .long_read_in(1'b0), .ready_out(host_ready), .data_out(host_data), .done_out(host_done));
    tsp_link_monitor #(.CONV_CYCLES(CONV)) i_tsp_link_monitor (
        .clk_in(clk_in), .rst_in(rst_in), .cs_n(link.cs_n), .sclk(link.sclk),
        .serial_in_pin(link.serial_in_pin), .serial_out_pin(link.serial_out_pin),
        .serial_out_oe(link.serial_out_oe), .pen_touch_irq_n(link.pen_touch_irq_n));

    initial begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end

    task automatic wrap_up;
        $display("Comparisons %0d, mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : wrap_up

    // Pulse counters and the hang guard
    always @(posedge clk_in) begin
        cycles <= cycles + 1;
        if (cmd_valid === 1'b1) n_cmds <= n_cmds + 1;
        if (conv_done === 1'b1) n_conv <= n_conv + 1;
        if (cycles == 60000) begin
            n_errors = n_errors + 1;
            wrap_up;
        end
    end

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    function automatic logic [15:0] word(input int i);
        return {8'h5A ^ 8'(i), 8'(i) ^ 8'hC3};
    endfunction : word

    task automatic push(input logic [15:0] w);
        @(negedge clk_in);
        res_data_in = w;
        res_valid_in = 1'b1;
    endtask : push

    // One whole frame; the host is idle again once done has been seen
    task automatic xfer(input logic [7:0] cmd, input logic [15:0] exp);
        int n;
        repeat (2) @(negedge clk_in);
        start_in = 1'b1;
        cmd_in = cmd;
        @(negedge clk_in);
        start_in = 1'b0;
        n = 0;
        while (host_done !== 1'b1 && n < 3000) begin
            @(negedge clk_in);
            n++;
        end
        // A frame that never ends is a mismatch of its own
        if (n >= 3000) begin
            n_errors++;
            $display("ERROR at %0t: frame timeout done %h expected %h", $time, host_done, 1'b1);
        end
        check(host_data, exp);
        check({8'h00, cmd_byte}, {8'h00, cmd});
    endtask : xfer

    task automatic touch(input logic t, input logic exp_n);
        @(negedge clk_in);
        pen_touch_in = t;
        repeat (3) @(negedge clk_in);
        check({15'h0000, link.pen_touch_irq_n}, {15'h0000, exp_n});
    endtask : touch

    initial begin
        logic [7:0] k;
        logic [15:0] w;
        rst_in = 1'b1;
        start_in = 1'b0;
        cmd_in = 8'h00;
        pen_touch_in = 1'b0;
        res_data_in = 16'h0000;
        res_valid_in = 1'b0;
        repeat (8) @(negedge clk_in);
        rst_in = 1'b0;
        check({12'h000, link.cs_n, link.sclk, link.pen_touch_irq_n, link.serial_out_oe}, 16'h000A);
        check({14'h0000, host_ready, res_ready}, 16'h0003);
        // Empty buffer gives a zero result
        xfer(8'hB0, 16'h0000);
        // Fill until refused; the extra word must be dropped
        for (int i = 0; i < 33; i++) push(word(i));
        @(negedge clk_in);
        res_valid_in = 1'b0;
        check({15'h0000, res_ready}, 16'h0000);
        // Drain with alternating long and short reads
        for (int i = 0; i < 32; i++) begin
            k = 8'(i);
            w = word(i);
            xfer({1'b1, k[2:0], k[0], 3'h7}, k[0] ? {8'h00, w[15:8]} : w);
        end
        check({15'h0000, res_ready}, 16'h0001);
        xfer(8'hC8, 16'h0000);
        // Touch, convert while touched, release and touch again
        touch(1'b1, 1'b0);
        xfer(8'h90, 16'h0000);
        check({15'h0000, link.pen_touch_irq_n}, 16'h0001);
        touch(1'b0, 1'b1);
        touch(1'b1, 1'b0);
        touch(1'b0, 1'b1);
        check(16'(n_cmds), 16'h0023);
        check(16'(n_conv), 16'h0023);
        check({15'h0000, conv_busy}, 16'h0000);
        wrap_up;
    end
endmodule : tb_top
